// ===== pif_assertions.sv
// Checker for the peripheral interrupt flag block
`timescale 1ns/100ps
module pif_assertions
  import pif_pkg::*;
(
  // Clock and reset
  input wire logic        clk,
  input wire logic        sys_rst,
  // Register bus
  input wire logic        hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0]  htrans,
  input wire logic        hwrite,
  input wire logic [2:0]  hsize,
  input wire logic [31:0] hwdata,
  input wire logic        hready,
  input wire logic [31:0] hrdata,
  input wire logic        hreadyout,
  input wire logic        hresp,
  // Outputs under watch
  input wire logic        rx_data_read,
  input wire logic        tx_data_write,
  input wire logic [7:0]  tx_data,
  input wire logic        periph_request,
  input wire logic        global_irq_enable
);
  logic take, rd, wr, wr_ctl, pen;
  assign take = hsel && hready && htrans[1] && hsize == 3'h2 && haddr[31:8] == 24'h0;
  assign rd = take && !hwrite;
  assign wr = take && hwrite;
  // Shadow of the peripheral enable bit
  always_ff @(posedge clk) begin
    if (sys_rst) wr_ctl <= 1'b0;
    else wr_ctl <= wr && haddr[7:0] == PIF_OFS_CONTROL;
  end
  always_ff @(posedge clk) begin
    if (sys_rst) pen <= 1'b0;
    else if (wr_ctl) pen <= hwdata[PIF_BC_PERIPH_EN];
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (sys_rst);
  sequence s_tx_addr;
    wr && haddr[7:0] == PIF_OFS_TX_DATA;
  endsequence
  sequence s_tx_pulse;
    ##1 (tx_data_write && tx_data == $past(hwdata[7:0]));
  endsequence
  a_rx_read_pulse: assert property (rd && haddr[7:0] == PIF_OFS_RX_DATA |=> rx_data_read)
    else $error("rx read strobe missing");
  a_tx_write_pulse: assert property (s_tx_addr |=> s_tx_pulse)
    else $error("tx write strobe or data wrong");
  a_unimpl_first: assert property (rd && haddr[7:0] == PIF_OFS_FLAGS_1 |=> hrdata[31:7] == 25'h0)
    else $error("unused bits of first flag word set");
  a_unimpl_second: assert property (rd && haddr[7:0] == PIF_OFS_FLAGS_2 |=> !hrdata[1])
    else $error("unused bit of second flag word set");
  a_rdata_idle: assert property (!$past(rd) |-> hrdata == 32'h0)
    else $error("read data outside a read");
  a_reset_clean: assert property ($fell(sys_rst) |-> !periph_request && !global_irq_enable)
    else $error("outputs not cleared by reset");
  a_zero_wait: assert property (hreadyout && !hresp)
    else $error("bus stalled or errored");
  a_periph_gate: assert property (!pen && !$past(pen) |-> !periph_request)
    else $error("request without peripheral enable");
  a_global_bit: assert property ($past(wr_ctl) |-> global_irq_enable == $past(hwdata[1]))
    else $error("global enable not stored");
endmodule // pif_assertions

// ===== pif_flags.sv
// Peripheral interrupt request flags with enables and an AHB-Lite register slave
`timescale 1ns/100ps

module pif_flags
  import pif_pkg::*;
(
  // Clock and reset
  input  wire logic          clk,
  input  wire logic          sys_rst,
  // AHB-Lite slave
  input  wire logic          hsel,
  input  wire logic [31:0]   haddr,
  input  wire logic [1:0]    htrans,
  input  wire logic          hwrite,
  input  wire logic [2:0]    hsize,
  input  wire logic [31:0]   hwdata,
  input  wire logic          hready,
  output logic      [31:0]   hrdata,
  output logic               hreadyout,
  output logic               hresp,
  // Peripheral events and levels
  input  wire pif_event_type periph_event,
  input  wire pif_level_type periph_level,
  // Data register accesses seen by the serial unit
  output logic               rx_data_read,
  output logic               tx_data_write,
  output logic      [7:0]    tx_data,
  // Core side
  output logic               periph_request,
  output logic               global_irq_enable
);

  // ----------------------------------------------------------------------
  // State
  // ----------------------------------------------------------------------
  logic [7:0]    flags_1;
  logic [7:0]    flags_2;
  logic [7:0]    enable_1;
  logic [7:0]    enable_2;
  logic          periph_irq_enable;
  logic [1:0]    comp_now;
  logic [1:0]    comp_prev;
  logic [1:0]    comp_change;
  logic          comp_seen;
  pif_state_type state;
  logic [7:0]    ph_addr;
  logic          ph_write;
  logic          ph_word;
  logic [7:0]    next_flags_1;
  logic [7:0]    next_flags_2;
  logic [7:0]    set_1;
  logic [7:0]    set_2;
  logic [7:0]    view_1;
  logic [7:0]    view_2;
  logic          wr_flags_1;
  logic          wr_flags_2;
  logic          rd_rx;
  logic          addr_take;
  logic          word_ok;
  logic          data_write;
  logic          wr_enable_1;
  logic          wr_enable_2;
  logic          wr_control;
  logic          wr_tx;
  pif_state_type next_state;
  logic [31:0]   next_hrdata;
  logic [7:0]    gated_1;
  logic [7:0]    gated_2;

  // ----------------------------------------------------------------------
  // Bus address phase
  // ----------------------------------------------------------------------
  assign addr_take = hsel & hready & htrans[1];
  // Only whole words inside the 256-byte window decode
  assign word_ok   = (hsize == 3'h2) && (haddr[31:8] == 24'h000000);

  // A taken address phase is always followed by exactly one data phase
  always_comb begin
    next_state = state;
    case (state)
      PIF_ST_IDLE: begin
        if (addr_take) begin
          next_state = PIF_ST_DATA;
        end
      end
      PIF_ST_DATA: begin
        if (!addr_take) begin
          next_state = PIF_ST_IDLE;
        end
      end
      default: begin
        next_state = PIF_ST_IDLE;
      end
    endcase
  end

  // Bus phase register
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      state <= PIF_ST_IDLE;
    end else begin
      state <= next_state;
    end
  end

  // Address phase capture, held through the data phase
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      ph_addr  <= 8'h00;
      ph_write <= 1'b0;
      ph_word  <= 1'b0;
    end else if (addr_take) begin
      ph_addr  <= haddr[7:0];
      ph_write <= hwrite;
      ph_word  <= word_ok;
    end
  end

  // ----------------------------------------------------------------------
  // Bus response
  // ----------------------------------------------------------------------
  // Zero wait states: every data phase ends at the next edge
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end else begin
      hreadyout <= 1'b1;
      hresp     <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // Register selects
  // ----------------------------------------------------------------------
  // Writes land in the data phase, when hwdata stands
  assign data_write  = (state == PIF_ST_DATA) && ph_write && ph_word;
  assign wr_flags_1  = data_write && (ph_addr == PIF_OFS_FLAGS_1);
  assign wr_flags_2  = data_write && (ph_addr == PIF_OFS_FLAGS_2);
  assign wr_enable_1 = data_write && (ph_addr == PIF_OFS_ENABLE_1);
  assign wr_enable_2 = data_write && (ph_addr == PIF_OFS_ENABLE_2);
  assign wr_control  = data_write && (ph_addr == PIF_OFS_CONTROL);
  assign wr_tx       = data_write && (ph_addr == PIF_OFS_TX_DATA);
  // Read strobe of the receive data register, decoded in the address phase
  assign rd_rx       = addr_take && !hwrite && word_ok
                       && (haddr[7:0] == PIF_OFS_RX_DATA);

  // ----------------------------------------------------------------------
  // Event sources
  // ----------------------------------------------------------------------
  // Comparator outputs, bit 0 for comparator a and bit 1 for comparator b
  assign comp_now = {periph_level.comparator_b_output, periph_level.comparator_a_output};

  // The first edge after reset only loads the history, so a high output sets nothing
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      comp_prev <= 2'h0;
      comp_seen <= 1'b0;
    end else begin
      comp_prev <= comp_now;
      comp_seen <= 1'b1;
    end
  end

  for (genvar i = 0; i < 2; i++) begin : g_comp
    assign comp_change[i] = comp_seen & (comp_now[i] ^ comp_prev[i]);
  end

  always_comb begin
    set_1 = 8'h00;
    set_2 = 8'h00;
    set_1[PIF_B1_CONV_DONE] = periph_event.conv_done;
    set_1[PIF_B1_SYNC_SER]  = periph_event.sync_xfer_done
      | (periph_event.i2c_seq_done & periph_level.i2c_master)
      | (periph_event.i2c_bus_cond_idle & periph_level.sync_idle);
    set_1[PIF_B1_CAPCMP_A]  =
        (periph_event.capture_a & (periph_level.capcmp_a_mode == PIF_CC_CAPTURE))
      | (periph_event.compare_a & (periph_level.capcmp_a_mode == PIF_CC_COMPARE));
    set_1[PIF_B1_TIMER_B]   = periph_event.timer_b_match;
    set_1[PIF_B1_TIMER_A]   = periph_event.timer_a_overflow;
    set_2[PIF_B2_OSC_FAIL]  = periph_event.osc_fail;
    set_2[PIF_B2_COMP_B]    = comp_change[1];
    set_2[PIF_B2_COMP_A]    = comp_change[0];
    set_2[PIF_B2_NV_WRITE]  = periph_event.nv_write_done;
    set_2[PIF_B2_BUS_COLL]  = periph_event.bus_collision
      & periph_level.i2c_master;
    set_2[PIF_B2_WAKE]      = periph_event.lowpower_wake;
    set_2[PIF_B2_CAPCMP_B]  =
        (periph_event.capture_b & (periph_level.capcmp_b_mode == PIF_CC_CAPTURE))
      | (periph_event.compare_b & (periph_level.capcmp_b_mode == PIF_CC_COMPARE));
  end

  // ----------------------------------------------------------------------
  // Sticky flags: write first, then events set over it
  // ----------------------------------------------------------------------
  always_comb begin
    next_flags_1 = flags_1;
    next_flags_2 = flags_2;
    if (wr_flags_1) begin
      next_flags_1 = (flags_1 & ~PIF_WR_1) | (hwdata[7:0] & PIF_WR_1);
    end
    if (wr_flags_2) begin
      next_flags_2 = (flags_2 & ~PIF_WR_2) | (hwdata[7:0] & PIF_WR_2);
    end
    // Events go last, so a set wins over a clearing write in the same cycle
    next_flags_1 = (next_flags_1 | set_1) & PIF_WR_1 & PIF_IMPL_1;
    next_flags_2 = (next_flags_2 | set_2) & PIF_WR_2 & PIF_IMPL_2;
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_1 <= PIF_RST_FLAGS;
    end else begin
      flags_1 <= next_flags_1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      flags_2 <= PIF_RST_FLAGS;
    end else begin
      flags_2 <= next_flags_2;
    end
  end

  // Read-only serial flags follow the buffer levels
  always_comb begin
    view_1 = flags_1;
    view_1[PIF_B1_RX_READY] = periph_level.rx_buffer_full;
    view_1[PIF_B1_TX_READY] = periph_level.tx_buffer_empty;
    view_1 = view_1 & PIF_IMPL_1;
    view_2 = flags_2 & PIF_IMPL_2;
  end

  // ----------------------------------------------------------------------
  // Enable and control registers
  // ----------------------------------------------------------------------
  // Enables mask the unimplemented positions
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_1 <= PIF_RST_ENABLE;
    end else if (wr_enable_1) begin
      enable_1 <= hwdata[7:0] & PIF_IMPL_1;
    end
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      enable_2 <= PIF_RST_ENABLE;
    end else if (wr_enable_2) begin
      enable_2 <= hwdata[7:0] & PIF_IMPL_2;
    end
  end

  // Global enable is only stored for the core; the request gate uses the peripheral bit
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_irq_enable <= PIF_RST_CONTROL[PIF_BC_PERIPH_EN];
      global_irq_enable <= PIF_RST_CONTROL[PIF_BC_GLOBAL_EN];
    end else if (wr_control) begin
      periph_irq_enable <= hwdata[PIF_BC_PERIPH_EN];
      global_irq_enable <= hwdata[PIF_BC_GLOBAL_EN];
    end
  end

  // ----------------------------------------------------------------------
  // Serial data register strobes
  // ----------------------------------------------------------------------
  // Tells the serial unit that the receive buffer was read
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      rx_data_read <= 1'b0;
    end else begin
      rx_data_read <= rd_rx;
    end
  end

  // Tells the serial unit that the transmit buffer was written
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_data_write <= 1'b0;
    end else begin
      tx_data_write <= wr_tx;
    end
  end

  // Byte handed to the serial transmitter
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      tx_data <= 8'h00;
    end else if (wr_tx) begin
      tx_data <= hwdata[7:0];
    end
  end

  // ----------------------------------------------------------------------
  // Combined request to the core
  // ----------------------------------------------------------------------
  // Each flag counts only with the enable bit at its own position
  for (genvar i = 0; i < 8; i++) begin : g_gate
    assign gated_1[i] = view_1[i] & enable_1[i];
    assign gated_2[i] = view_2[i] & enable_2[i];
  end

  always_ff @(posedge clk) begin
    if (sys_rst) begin
      periph_request <= 1'b0;
    end else begin
      periph_request <= periph_irq_enable
        & (|(gated_1 | gated_2));
    end
  end

  // ----------------------------------------------------------------------
  // Read data, registered for the data phase
  // ----------------------------------------------------------------------
  // Read data mux, looked up in the address phase
  always_comb begin
    next_hrdata = 32'h00000000;
    if (addr_take && !hwrite && word_ok) begin
      case (haddr[7:0])
        PIF_OFS_FLAGS_1: begin
          next_hrdata = {24'h000000, view_1};
        end
        PIF_OFS_FLAGS_2: begin
          next_hrdata = {24'h000000, view_2};
        end
        PIF_OFS_ENABLE_1: begin
          next_hrdata = {24'h000000, enable_1};
        end
        PIF_OFS_ENABLE_2: begin
          next_hrdata = {24'h000000, enable_2};
        end
        PIF_OFS_CONTROL: begin
          next_hrdata = {30'h0, global_irq_enable, periph_irq_enable};
        end
        default: begin
          next_hrdata = 32'h00000000;
        end
      endcase
    end
  end

  // Registered so that read data stand for the data phase only
  always_ff @(posedge clk) begin
    if (sys_rst) begin
      hrdata <= 32'h00000000;
    end else begin
      hrdata <= next_hrdata;
    end
  end

endmodule // pif_flags

// ===== pif_flags_tb_top.sv
// Self-checking testbench for the peripheral interrupt flag block
`timescale 1ns/100ps
module pif_flags_tb_top
  import pif_pkg::*;
;
  logic clk = 1'b0, sys_rst = 1'b1, hsel = 1'b0, hwrite = 1'b0, rd_dp = 1'b0;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
  logic [1:0] htrans = 2'h0;
  logic [2:0] hsize = 3'h2;
  logic hready, hreadyout, hresp, rx_data_read, tx_data_write;
  logic periph_request, global_irq_enable;
  logic [7:0] tx_data, b;
  logic [15:0] e;
  pif_event_type ev_req = '0, periph_event;
  pif_level_type lv = '0, periph_level;
  logic [31:0] exp_q[$];
  int err_count = 0, total_checks = 0, cycles = 0;
  assign hready = hreadyout;
  always #25 clk = ~clk;
  pif_periph_model PM (.clk, .sys_rst, .ev_req, .lv_req(lv), .periph_event, .periph_level);
  pif_flags DUT (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .hready,
    .hrdata, .hreadyout, .hresp, .periph_event, .periph_level, .rx_data_read,
    .tx_data_write, .tx_data, .periph_request, .global_irq_enable);
  task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
    total_checks++;
    if (got !== exp) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask
  // One single transfer; read data is judged by the monitor
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    hsel <= 1'b1;
    htrans <= 2'h2;
    hwrite <= w;
    haddr <= {24'h0, a};
    do @(posedge clk); while (hreadyout !== 1'b1);
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= d;
    rd_dp <= !w;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd_dp <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    bus(1'b1, a, d);
  endtask
  task automatic rd(input logic [7:0] a, input logic [31:0] x);
    exp_q.push_back(x);
    bus(1'b0, a, 32'h0);
  endtask
  task automatic fire(input int i);
    @(posedge clk);
    ev_req <= pif_event_type'(14'h1 << i);
    @(posedge clk);
    ev_req <= '0;
    repeat (2) @(posedge clk);
  endtask
  task automatic chk_req(input logic x);
    repeat (3) @(posedge clk);
    cmp("periph_request", {31'h0, x}, {31'h0, periph_request});
  endtask
  // Expected {first, second} flag words for each event strobe
  function automatic logic [15:0] fexp(input int i, input logic on);
    case (i)
      13: return 16'h4000;
      12: return 16'h0800;
      11, 10: return on ? 16'h0800 : 16'h0;
      9, 8: return on ? 16'h0400 : 16'h0;
      7, 6: return on ? 16'h0001 : 16'h0;
      5: return 16'h0200;
      4: return 16'h0100;
      3: return 16'h0080;
      2: return 16'h0010;
      1: return on ? 16'h0008 : 16'h0;
      default: return 16'h0004;
    endcase
  endfunction
  always @(posedge clk) begin
    if (rd_dp && hreadyout === 1'b1) cmp("hrdata", exp_q.pop_front(), hrdata);
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 20000) begin
      err_count++;
      print_verdict();
    end
  end
  initial begin
    void'($urandom(32'h42b0));
    repeat (2) @(posedge clk);
    sys_rst <= 1'b0;
    for (int a = 0; a < 8'h48; a += 4) rd(8'(a), 32'h0);
    $display("reset values done");
    for (int p = 0; p < 2; p++) begin
      for (int i = 0; i < 14; i++) begin
        lv.capcmp_a_mode <= p ? (i == 9 ? PIF_CC_COMPARE : PIF_CC_PWM)
                              : (i == 9 ? PIF_CC_CAPTURE : PIF_CC_COMPARE);
        lv.capcmp_b_mode <= p ? (i == 7 ? PIF_CC_OFF : PIF_CC_PWM)
                              : (i == 7 ? PIF_CC_CAPTURE : PIF_CC_COMPARE);
        lv.i2c_master <= (p == 0);
        lv.sync_idle <= (p == 0);
        fire(i);
        e = fexp(i, p == 0);
        rd(PIF_OFS_FLAGS_1, {24'h0, e[15:8]});
        rd(PIF_OFS_FLAGS_2, {24'h0, e[7:0]});
        wr(PIF_OFS_FLAGS_1, 32'h0);
        wr(PIF_OFS_FLAGS_2, 32'h0);
      end
    end
    $display("event flags done");
    for (int k = 0; k < 4; k++) begin
      b = 8'($urandom);
      lv.rx_buffer_full <= b[0];
      lv.tx_buffer_empty <= b[1];
      wr(PIF_OFS_FLAGS_1, {24'h0, b});
      rd(PIF_OFS_FLAGS_1, {24'h0, b & 8'h4f | {2'h0, b[0], b[1], 4'h0}});
      wr(PIF_OFS_FLAGS_2, {24'h0, b});
      rd(PIF_OFS_FLAGS_2, {24'h0, b & 8'hfd});
      rd(PIF_OFS_RX_DATA, 32'h0);
      wr(PIF_OFS_TX_DATA, {24'h0, b});
      @(posedge clk);
      cmp("tx_data", {24'h0, b}, {24'h0, tx_data});
    end
    lv.rx_buffer_full <= 1'b0;
    lv.tx_buffer_empty <= 1'b0;
    wr(PIF_OFS_FLAGS_2, 32'h0);
    lv.comparator_a_output <= 1'b1;
    lv.comparator_b_output <= 1'b1;
    rd(PIF_OFS_FLAGS_2, 32'h60);
    wr(PIF_OFS_FLAGS_2, 32'h0);
    rd(PIF_OFS_FLAGS_2, 32'h0);
    wr(PIF_OFS_FLAGS_1, 32'h0);
    $display("software access done");
    for (int k = 0; k < 16; k++) begin
      e = 16'h1 << k;
      if ((e & 16'h4ffd) == 16'h0) continue;
      b = 8'($urandom);
      wr(PIF_OFS_FLAGS_1, {24'h0, e[15:8]});
      wr(PIF_OFS_FLAGS_2, {24'h0, e[7:0]});
      wr(PIF_OFS_ENABLE_1, {24'h0, ~e[15:8]});
      wr(PIF_OFS_ENABLE_2, {24'h0, ~e[7:0]});
      wr(PIF_OFS_CONTROL, 32'h1);
      chk_req(1'b0);
      wr(PIF_OFS_ENABLE_1, {24'h0, e[15:8]});
      wr(PIF_OFS_ENABLE_2, {24'h0, e[7:0]});
      wr(PIF_OFS_CONTROL, {30'h0, b[0], 1'b0});
      chk_req(1'b0);
      cmp("global_irq_enable", {31'h0, b[0]}, {31'h0, global_irq_enable});
      wr(PIF_OFS_CONTROL, 32'h1);
      chk_req(1'b1);
      wr(PIF_OFS_FLAGS_1, 32'h0);
      wr(PIF_OFS_FLAGS_2, 32'h0);
      chk_req(1'b0);
    end
    $display("request gating done");
    print_verdict();
  end
endmodule // pif_flags_tb_top

bind pif_flags pif_assertions u_chk (.clk, .sys_rst, .hsel, .haddr, .htrans, .hwrite, .hsize,
  .hwdata, .hready, .hrdata, .hreadyout, .hresp, .rx_data_read, .tx_data_write, .tx_data,
  .periph_request, .global_irq_enable);

// ===== pif_periph_model.sv
// Model of the peripheral event sources feeding the flag block
`timescale 1ns/100ps
module pif_periph_model
  import pif_pkg::*;
(
  // Clock and reset
  input wire logic          clk,
  input wire logic          sys_rst,
  // Requests from the bench
  input wire pif_event_type ev_req,
  input wire pif_level_type lv_req,
  // Toward the flag block
  output pif_event_type     periph_event,
  output pif_level_type     periph_level
);
  // Each requested event becomes a single-cycle strobe
  always_ff @(posedge clk) begin
    if (sys_rst) periph_event <= '0;
    else periph_event <= ev_req & ~periph_event;
  end
  assign periph_level = lv_req;
endmodule // pif_periph_model

// ===== pif_pkg.sv
// Package for the peripheral interrupt flag block: register map, bit positions, carriers
package pif_pkg;

  // ----------------------------------------------------------------------
  // Register map (byte addresses on the AHB-Lite slave)
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIF_OFS_FLAGS_1  = 8'h00;
  localparam logic [7:0] PIF_OFS_FLAGS_2  = 8'h04;
  localparam logic [7:0] PIF_OFS_ENABLE_1 = 8'h08;
  localparam logic [7:0] PIF_OFS_ENABLE_2 = 8'h0c;
  localparam logic [7:0] PIF_OFS_CONTROL  = 8'h10;
  localparam logic [7:0] PIF_OFS_RX_DATA  = 8'h14;
  localparam logic [7:0] PIF_OFS_TX_DATA  = 8'h18;

  // ----------------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIF_RST_FLAGS   = 8'h00;
  localparam logic [7:0] PIF_RST_ENABLE  = 8'h00;
  localparam logic [1:0] PIF_RST_CONTROL = 2'h0;

  // ----------------------------------------------------------------------
  // Implemented bits and software-writable bits
  // ----------------------------------------------------------------------
  localparam logic [7:0] PIF_IMPL_1 = 8'h7f;
  localparam logic [7:0] PIF_IMPL_2 = 8'hfd;
  localparam logic [7:0] PIF_WR_1   = 8'h4f;
  localparam logic [7:0] PIF_WR_2   = 8'hfd;

  // ----------------------------------------------------------------------
  // Bit positions, first request register
  // ----------------------------------------------------------------------
  localparam int PIF_B1_CONV_DONE = 6;
  localparam int PIF_B1_RX_READY  = 5;
  localparam int PIF_B1_TX_READY  = 4;
  localparam int PIF_B1_SYNC_SER  = 3;
  localparam int PIF_B1_CAPCMP_A  = 2;
  localparam int PIF_B1_TIMER_B   = 1;
  localparam int PIF_B1_TIMER_A   = 0;

  // ----------------------------------------------------------------------
  // Bit positions, second request register and control register
  // ----------------------------------------------------------------------
  localparam int PIF_B2_OSC_FAIL  = 7;
  localparam int PIF_B2_COMP_B    = 6;
  localparam int PIF_B2_COMP_A    = 5;
  localparam int PIF_B2_NV_WRITE  = 4;
  localparam int PIF_B2_BUS_COLL  = 3;
  localparam int PIF_B2_WAKE      = 2;
  localparam int PIF_B2_CAPCMP_B  = 0;
  localparam int PIF_BC_PERIPH_EN = 0;
  localparam int PIF_BC_GLOBAL_EN = 1;

  // ----------------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {
    PIF_CC_OFF     = 2'h0,
    PIF_CC_CAPTURE = 2'h1,
    PIF_CC_COMPARE = 2'h2,
    PIF_CC_PWM     = 2'h3
  } pif_ccmode_type;

  typedef enum logic [1:0] {
    PIF_ST_IDLE = 2'b00,
    PIF_ST_DATA = 2'b01
  } pif_state_type;

  // Event strobes from the peripherals, one cycle each
  typedef struct packed {
    logic conv_done;
    logic sync_xfer_done;
    logic i2c_seq_done;
    logic i2c_bus_cond_idle;
    logic capture_a;
    logic compare_a;
    logic capture_b;
    logic compare_b;
    logic timer_b_match;
    logic timer_a_overflow;
    logic osc_fail;
    logic nv_write_done;
    logic bus_collision;
    logic lowpower_wake;
  } pif_event_type;

  // Levels from the peripherals
  typedef struct packed {
    pif_ccmode_type capcmp_a_mode;
    pif_ccmode_type capcmp_b_mode;
    logic           i2c_master;
    logic           sync_idle;
    logic           rx_buffer_full;
    logic           tx_buffer_empty;
    logic           comparator_a_output;
    logic           comparator_b_output;
  } pif_level_type;

endpackage : pif_pkg
